/* inc/pwrpin_pkg.sv */
// Package of constants and types for the power-control pin block
`default_nettype none
package pwrpin_pkg;
  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 10_000_000;
  localparam int CLK_NS = 1_000_000_000 / CLK_HZ;
  localparam int DEBOUNCE_MS = 65;
  localparam int DEBOUNCE_CYC = DEBOUNCE_MS * (CLK_HZ / 1000);
  localparam int WAKE_SHORT_S = 1;
  localparam int WAKE_LONG_S = 5;
  localparam int WAKE_SHORT_CYC = WAKE_SHORT_S * CLK_HZ;
  localparam int WAKE_LONG_CYC = WAKE_LONG_S * CLK_HZ;
  localparam int RX_WAKE_US = 128;
  localparam int RX_WAKE_CYC = (RX_WAKE_US * (CLK_HZ / 1000) + 999) / 1000;
  localparam int SLEEP_DELAY_MS = 1000;
  localparam int SLEEP_DELAY_CYC = SLEEP_DELAY_MS * (CLK_HZ / 1000);
  localparam int WARN_DELAY_MS = 2000;
  localparam int WARN_DELAY_CYC = WARN_DELAY_MS * (CLK_HZ / 1000);
  localparam int ADC_MS = 9;
  localparam int ADC_CYC = ADC_MS * (CLK_HZ / 1000);
  // ----------------------------------------------------------------
  // Power options parameter fields and reset value
  // ----------------------------------------------------------------
  localparam int OPT_ENABLE_BIT = 7;
  localparam int OPT_LEVEL_BIT = 6;
  localparam int OPT_MONITOR_BIT = 2;
  localparam int OPT_WAKE_BIT = 1;
  localparam logic [7:0] OPT_RESET = 8'h80;
  // ----------------------------------------------------------------
  // Power states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    PWRPIN_RUN,
    PWRPIN_PEND,
    PWRPIN_STANDBY,
    PWRPIN_RESTART
  } pwrpin_state_t;
endpackage : pwrpin_pkg
`default_nettype wire

/* rtl/pwrpin_timer.sv */
// Down-counting one-shot timer with start, cancel and done pulse
`default_nettype none
module pwrpin_timer
  import pwrpin_pkg::*;
#(
  parameter int W = 32
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Control
  input wire logic start,
  input wire logic cancel,
  input wire logic [W-1:0] load,
  // Status
  output logic busy,
  output logic done
);
  logic [W-1:0] count;

  // ----------------------------------------------------------------
  // Count down once per cycle, pulse done the cycle after the count reaches one
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!nrst) begin
      count <= '0;
      busy <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (cancel) begin
        busy <= 1'b0;
      end else if (start) begin
        count <= load;
        busy <= 1'b1;
      end else if (busy) begin
        if (count <= W'(1)) begin
          busy <= 1'b0;
          done <= 1'b1;
        end else begin
          count <= count - W'(1);
        end
      end
    end
  end
endmodule : pwrpin_timer
`default_nettype wire

/* rtl/pwrpin_lowcnt.sv */
// Counter of consecutive low cycles with threshold flag
`default_nettype none
module pwrpin_lowcnt
  import pwrpin_pkg::*;
#(
  parameter int W = 32
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Sampled line and threshold
  input wire logic line,
  input wire logic [W-1:0] limit,
  // Result
  output logic reached
);
  logic [W-1:0] count;

  // ----------------------------------------------------------------
  // Restart on a high level, saturate at the limit
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!nrst) begin
      count <= '0;
      reached <= 1'b0;
    end else if (line) begin
      count <= '0;
      reached <= 1'b0;
    end else if (count < limit) begin
      count <= count + W'(1);
      reached <= (count + W'(1)) >= limit;
    end
  end
endmodule : pwrpin_lowcnt
`default_nettype wire

/* rtl/pwrpin_ctrl.sv */
// Power-control, handshake, lamp and timing pin logic of the bridge
//
// Design decisions made here: the address-and-strobe port and the address map.
`default_nettype none
// Operation
// - The input is an ignition monitor only when option bits 7 and 2 are set.
// - In monitor mode a low held through the debounce time enters standby.
// - After the input goes high again, wait 1 s or 5 s by bit 1, then restart.
// - Any rising edge of the input wakes the device from standby.
// - With bit 7 or bit 2 clear the input is an active-low request to send.
// - With bit 7 set the output rests at bit 6 and flips in standby.
// - With bit 7 clear the output is high while busy and low when idle.
// - The transmit pin idles high and the host keeps the receive pin high.
// - The four lamp outputs idle high and go low during their transfers.
// - A low pulse of at least 128 us on the receive pin wakes from standby.
// - The output takes its standby level about 1.0 s after the sleep command.
// - The output takes its standby level about 2.0 s after the warning.
// - The voltage response starts about 9 ms after the read command.
// - The oscillator stops in standby so the clocked logic halts; here only osc_run drops, and this logic keeps running on clk.
module pwrpin_ctrl
  import pwrpin_pkg::*;
#(
  parameter int DEBOUNCE_CYCLES = DEBOUNCE_CYC,
  parameter int WAKE_SHORT_CYCLES = WAKE_SHORT_CYC,
  parameter int WAKE_LONG_CYCLES = WAKE_LONG_CYC,
  parameter int SLEEP_CYCLES = SLEEP_DELAY_CYC,
  parameter int WARN_CYCLES = WARN_DELAY_CYC,
  parameter int ADC_CYCLES = ADC_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Register port
  input wire logic [1:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  // Interrupt
  output logic irq,
  // Pins
  input wire logic ignition_monitor_input,
  input wire logic serial_receive_pin,
  output logic serial_transmit_pin,
  output logic power_level_output,
  // Core events and activity
  input wire logic cmd_busy,
  input wire logic sleep_command,
  input wire logic low_power_warning,
  input wire logic read_voltage_command,
  input wire logic tx_data,
  input wire logic tx_active,
  input wire logic rx_active,
  input wire logic veh_rx_active,
  input wire logic veh_tx_active,
  // Core controls
  output logic request_to_send,
  output logic voltage_reply_start,
  output logic osc_run,
  output logic warm_restart,
  output logic [3:0] lamp_n
);
  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [1:0] ADDR_OPTIONS = 2'h0;
  localparam logic [1:0] ADDR_STATUS = 2'h1;
  localparam logic [1:0] ADDR_MASK = 2'h2;
  localparam logic [1:0] ADDR_STATE = 2'h3;
  localparam int EV_STANDBY = 0;
  localparam int EV_WAKE = 1;
  localparam int EV_RTS = 2;
  localparam int EV_VOLT = 3;
  localparam int TW = 32;

  logic [7:0] power_options_parameter;
  logic [3:0] status;
  logic [3:0] mask;
  pwrpin_state_t state;
  pwrpin_state_t next_state;
  logic ign_prev;
  logic ign_rise;
  logic monitor_mode;
  logic ign_low_long;
  logic rx_low_long;
  logic sleep_due;
  logic sleep_busy;
  logic wake_done;
  logic wake_busy;
  logic volt_done;
  logic volt_busy;
  logic rts_prev;
  logic [3:0] events;
  logic wake_event;

  // Mode decode from the option byte
  function automatic logic is_monitor(input logic [7:0] opt);
    return opt[OPT_ENABLE_BIT] & opt[OPT_MONITOR_BIT];
  endfunction

  assign monitor_mode = is_monitor(power_options_parameter);
  assign ign_rise = ignition_monitor_input & ~ign_prev;

  // ----------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!nrst) begin
      power_options_parameter <= OPT_RESET;
      mask <= 4'h0;
    end else if (wr) begin
      if (addr == ADDR_OPTIONS) power_options_parameter <= wdata;
      if (addr == ADDR_MASK) mask <= wdata[3:0];
    end
  end

  // Read data, one cycle after the strobe
  always_ff @(posedge clk) begin
    if (!nrst) begin
      rdata <= 8'h00;
    end else if (rd) begin
      unique case (addr)
        ADDR_OPTIONS: rdata <= power_options_parameter;
        ADDR_STATUS: rdata <= {4'h0, status};
        ADDR_MASK: rdata <= {4'h0, mask};
        ADDR_STATE: rdata <= {6'h00, state};
      endcase
    end else begin
      rdata <= 8'h00;
    end
  end

  // ----------------------------------------------------------------
  // Debounce and receive-line wake detectors
  // ----------------------------------------------------------------
  pwrpin_lowcnt #(.W(TW)) u_debounce (
    .clk(clk),
    .nrst(nrst),
    .line(ignition_monitor_input | ~monitor_mode),
    .limit(TW'(DEBOUNCE_CYCLES)),
    .reached(ign_low_long)
  );

  pwrpin_lowcnt #(.W(TW)) u_rxwake (
    .clk(clk),
    .nrst(nrst),
    .line(serial_receive_pin),
    .limit(TW'(RX_WAKE_CYC)),
    .reached(rx_low_long)
  );

  // ----------------------------------------------------------------
  // Timers
  // ----------------------------------------------------------------
  pwrpin_timer #(.W(TW)) u_sleep (
    .clk(clk),
    .nrst(nrst),
    .start((sleep_command | low_power_warning) && state == PWRPIN_RUN),
    // Pending sleep dropped once run is left, no stale expiry later
    .cancel(state != PWRPIN_RUN),
    .load(low_power_warning ? TW'(WARN_CYCLES) : TW'(SLEEP_CYCLES)),
    .busy(sleep_busy),
    .done(sleep_due)
  );

  pwrpin_timer #(.W(TW)) u_wake (
    .clk(clk),
    .nrst(nrst),
    .start(state == PWRPIN_STANDBY && wake_event),
    // Nothing left to time once back in run
    .cancel(state == PWRPIN_RUN),
    .load(power_options_parameter[OPT_WAKE_BIT] ?
          TW'(WAKE_LONG_CYCLES) : TW'(WAKE_SHORT_CYCLES)),
    .busy(wake_busy),
    .done(wake_done)
  );

  pwrpin_timer #(.W(TW)) u_volt (
    .clk(clk),
    .nrst(nrst),
    .start(read_voltage_command),
    // Conversion abandoned when the oscillator is stopped
    .cancel(state == PWRPIN_STANDBY),
    .load(TW'(ADC_CYCLES)),
    .busy(volt_busy),
    .done(volt_done)
  );

  assign voltage_reply_start = volt_done;
  assign wake_event = ign_rise | rx_low_long;

  // ----------------------------------------------------------------
  // Power state machine
  // ----------------------------------------------------------------
  always_comb begin
    next_state = state;
    unique case (state)
      PWRPIN_RUN: begin
        if (ign_low_long) next_state = PWRPIN_STANDBY;
        else if (sleep_due) next_state = PWRPIN_STANDBY;
      end
      PWRPIN_PEND: next_state = PWRPIN_STANDBY;
      PWRPIN_STANDBY: begin
        if (wake_event) next_state = PWRPIN_RESTART;
      end
      PWRPIN_RESTART: begin
        if (wake_done) next_state = PWRPIN_RUN;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!nrst) state <= PWRPIN_RUN;
    else state <= next_state;
  end

  // Edge memory of the dual-function input
  always_ff @(posedge clk) begin
    if (!nrst) ign_prev <= 1'b1;
    else ign_prev <= ignition_monitor_input;
  end

  // Warm restart pulse and oscillator gate
  always_ff @(posedge clk) begin
    if (!nrst) begin
      warm_restart <= 1'b0;
      osc_run <= 1'b1;
    end else begin
      warm_restart <= state == PWRPIN_RESTART && wake_done;
      osc_run <= next_state != PWRPIN_STANDBY;
    end
  end

  // ----------------------------------------------------------------
  // Dual-function output and request to send
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!nrst) begin
      power_level_output <= OPT_RESET[OPT_LEVEL_BIT];
      request_to_send <= 1'b0;
    end else begin
      if (power_options_parameter[OPT_ENABLE_BIT])
        power_level_output <= power_options_parameter[OPT_LEVEL_BIT] ^
                              (next_state == PWRPIN_STANDBY);
      else
        power_level_output <= cmd_busy;
      request_to_send <= ~monitor_mode & ~ignition_monitor_input;
    end
  end

  // ----------------------------------------------------------------
  // Serial idle level and lamps
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!nrst) begin
      serial_transmit_pin <= 1'b1;
      lamp_n <= 4'hf;
    end else begin
      serial_transmit_pin <= tx_active ? tx_data : 1'b1;
      lamp_n <= ~{veh_tx_active, veh_rx_active, tx_active, rx_active};
    end
  end

  // ----------------------------------------------------------------
  // Interrupt status: set wins over read clear
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!nrst) rts_prev <= 1'b0;
    else rts_prev <= request_to_send;
  end

  assign events = {volt_done, request_to_send & ~rts_prev,
                   state == PWRPIN_RESTART && wake_done,
                   state != PWRPIN_STANDBY && next_state == PWRPIN_STANDBY};

  always_ff @(posedge clk) begin
    if (!nrst) status <= 4'h0;
    else if (rd && addr == ADDR_STATUS) status <= events;
    else status <= status | events;
  end

  assign irq = |(status & mask);

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence low_run_s;
    !ignition_monitor_input && monitor_mode;
  endsequence

  // Standby with a wake cause present
  sequence wake_s;
    state == PWRPIN_STANDBY && wake_event;
  endsequence

  debounce_entry_a: assert property (@(posedge clk) disable iff (!nrst)
    $rose(ign_low_long) && state == PWRPIN_RUN |=> state == PWRPIN_STANDBY)
    else $error("debounce did not enter standby");
  debounce_glitch_a: assert property (@(posedge clk) disable iff (!nrst)
    ignition_monitor_input |=> !ign_low_long)
    else $error("debounce not restarted by high");
  mode_rts_a: assert property (@(posedge clk) disable iff (!nrst)
    !is_monitor(power_options_parameter) && !ignition_monitor_input
    |=> request_to_send || $changed(power_options_parameter))
    else $error("request to send missing");
  mon_no_rts_a: assert property (@(posedge clk) disable iff (!nrst)
    low_run_s |=> !request_to_send || $changed(power_options_parameter))
    else $error("request to send in monitor mode");
  wake_edge_a: assert property (@(posedge clk) disable iff (!nrst)
    state == PWRPIN_STANDBY && ign_rise |=> state == PWRPIN_RESTART)
    else $error("rising edge did not wake");
  // Level follows the option byte seen at the launching edge
  power_level_a: assert property (@(posedge clk) disable iff (!nrst)
    power_options_parameter[OPT_ENABLE_BIT] |=> power_level_output ==
      ($past(power_options_parameter[OPT_LEVEL_BIT]) ^
       (state == PWRPIN_STANDBY)))
    else $error("power level wrong");
  busy_out_a: assert property (@(posedge clk) disable iff (!nrst)
    !power_options_parameter[OPT_ENABLE_BIT] ##1
    !$past(power_options_parameter[OPT_ENABLE_BIT], 1) |->
    power_level_output == $past(cmd_busy))
    else $error("busy output wrong");
  tx_idle_a: assert property (@(posedge clk) disable iff (!nrst)
    !tx_active |=> serial_transmit_pin)
    else $error("transmit not idle high");
  lamp_idle_a: assert property (@(posedge clk) disable iff (!nrst)
    !rx_active |=> lamp_n[0])
    else $error("lamp not idle high");
  lamp_busy_a: assert property (@(posedge clk) disable iff (!nrst)
    veh_tx_active |=> !lamp_n[3])
    else $error("lamp not low during transfer");
  osc_stop_a: assert property (@(posedge clk) disable iff (!nrst)
    state == PWRPIN_STANDBY |-> !osc_run)
    else $error("oscillator running in standby");
  wake_osc_a: assert property (@(posedge clk) disable iff (!nrst)
    wake_s |=> osc_run && state == PWRPIN_RESTART)
    else $error("oscillator not restarted on wake");
  rx_wake_a: assert property (@(posedge clk) disable iff (!nrst)
    rx_low_long && state == PWRPIN_STANDBY |=> state == PWRPIN_RESTART)
    else $error("receive pulse did not wake");
  restart_pulse_a: assert property (@(posedge clk) disable iff (!nrst)
    state == PWRPIN_RESTART && wake_done |=>
    warm_restart && state == PWRPIN_RUN)
    else $error("warm restart missing");
  volt_delay_a: assert property (@(posedge clk) disable iff (!nrst)
    volt_done |-> $past(volt_busy))
    else $error("voltage reply without conversion");
endmodule : pwrpin_ctrl
`default_nettype wire

/* testbench/pwrpin_host.sv */
// Host model driving the request line and the serial receive line
`default_nettype none
module pwrpin_host (
  // Clock
  input wire logic clk,
  // Busy level from the device
  input wire logic busy,
  // Lines towards the device
  output logic rts_n,
  output logic rx
);
  timeunit 1ns;
  timeprecision 1ns;
  // Both lines rest high
  initial begin
    rts_n = 1'b1;
    rx = 1'b1;
  end
  // Plain level change of the request line
  task automatic set_ign(input logic v);
    @(posedge clk);
    rts_n <= v;
  endtask
  // Ask for attention and hold until busy falls
  task automatic request(output int n);
    @(posedge clk);
    rts_n <= 1'b0;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (busy !== 1'b0 && n < 500);
    rts_n <= 1'b1;
  endtask
  // Low pulse on the receive line, then back to idle
  task automatic wake_pulse(input int len);
    @(posedge clk);
    rx <= 1'b0;
    repeat (len) @(posedge clk);
    rx <= 1'b1;
  endtask
endmodule // pwrpin_host
`default_nettype wire

/* testbench/tb_power_control_pin_functions.sv */
// Self-checking bench for the power-control pin block
`default_nettype none
module tb_power_control_pin_functions import pwrpin_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------------------------------
  // Shortened counts and signals
  // ----------------------------------------------------------------
  localparam int DEB = 20;
  localparam int WS = 30;
  localparam int WL = 60;
  localparam int SLP = 40;
  localparam int WRN = 80;
  localparam int ADC = 9;
  logic clk, nrst, wr, rd, irq, ign, rxp, txp, pwr, cmd_busy, tx_data;
  logic rts, vstart, osc, warm;
  logic [1:0] addr;
  logic [7:0] wdata, rdata, d;
  logic [2:0] cmds;
  logic [3:0] act, lamp_n;
  int n, n_mismatch, n_compared;
  // ----------------------------------------------------------------
  // Device and host
  // ----------------------------------------------------------------
  pwrpin_ctrl #(.DEBOUNCE_CYCLES(DEB), .WAKE_SHORT_CYCLES(WS),
    .WAKE_LONG_CYCLES(WL), .SLEEP_CYCLES(SLP), .WARN_CYCLES(WRN),
    .ADC_CYCLES(ADC)) uut (.clk(clk), .nrst(nrst), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .irq(irq),
    .ignition_monitor_input(ign), .serial_receive_pin(rxp),
    .serial_transmit_pin(txp), .power_level_output(pwr),
    .cmd_busy(cmd_busy), .sleep_command(cmds[0]),
    .low_power_warning(cmds[1]), .read_voltage_command(cmds[2]),
    .tx_data(tx_data), .tx_active(act[1]), .rx_active(act[0]),
    .veh_rx_active(act[2]), .veh_tx_active(act[3]),
    .request_to_send(rts), .voltage_reply_start(vstart), .osc_run(osc),
    .warm_restart(warm), .lamp_n(lamp_n));
  pwrpin_host host (.clk(clk), .busy(pwr), .rts_n(ign), .rx(rxp));
  // Clock of 100 ns
  always #50 clk = ~clk;
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic stop_test();
    $display("Compared %0d, mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [1:0] a, input logic [7:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // Read strobe, data taken in the following cycle
  task automatic rd_reg(input logic [1:0] a);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask
  task automatic rchk(input logic [1:0] a, input logic [7:0] exp);
    rd_reg(a);
    chk(d, exp);
  endtask
  // One-cycle pulse of a core command
  task automatic pulse(input int k);
    @(posedge clk);
    cmds[k] <= 1'b1;
    @(posedge clk);
    cmds[k] <= 1'b0;
    #1;
  endtask
  function automatic logic sig(input int k);
    case (k)
      0: return osc;
      1: return warm;
      default: return vstart;
    endcase
  endfunction
  // Count cycles until a watched output reaches a level
  task automatic cnt_until(input int k, input logic v);
    n = 0;
    while (sig(k) !== v && n < 3000) begin
      @(posedge clk);
      #1;
      n++;
    end
  endtask
  task automatic win(input int lo, input int hi);
    chk(8'(n >= lo && n <= hi), 8'h01);
  endtask
  task automatic sleep_via(input int k, input int dly, input logic lvl);
    pulse(k);
    cnt_until(0, 1'b0);
    win(dly - 1, dly + 3);
    @(posedge clk);
    #1;
    chk({7'h0, pwr}, {7'h0, lvl});
  endtask
  // ----------------------------------------------------------------
  // Watchdog and main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (60000) @(posedge clk);
    n_mismatch++;
    stop_test();
  end
  initial begin
    clk = 1'b0;
    nrst = 1'b0;
    {addr, wdata, wr, rd, cmd_busy, cmds, act} = '0;
    tx_data = 1'b1;
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    #1;
    chk({irq, txp, osc, pwr, rts, vstart, warm, 1'b0}, 8'h60);
    chk({4'h0, lamp_n}, 8'h0f);
    rchk(0, 8'h80);
    rchk(1, 8'h00);
    wr_reg(2, 8'h5a);
    rchk(2, 8'h0a);
    wr_reg(3, 8'hff);
    rchk(3, 8'h00);
    // Lamps follow their activity, transmit pin follows data
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      act <= 4'(1 << i);
      repeat (2) @(posedge clk);
      #1;
      chk({4'h0, lamp_n}, {4'h0, ~4'(1 << i)});
    end
    @(posedge clk);
    act <= 4'h2;
    tx_data <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    chk({7'h0, txp}, 8'h00);
    @(posedge clk);
    act <= 4'h0;
    repeat (2) @(posedge clk);
    #1;
    chk({3'h0, txp, lamp_n}, 8'h1f);
    // Request mode whenever one of the two option bits is clear
    wr_reg(2, 8'h00);
    for (int i = 0; i < 2; i++) begin
      wr_reg(0, i ? 8'h80 : 8'h04);
      host.set_ign(1'b0);
      repeat (DEB + 8) @(posedge clk);
      #1;
      chk({6'h0, osc, rts}, 8'h03);
      host.set_ign(1'b1);
      repeat (3) @(posedge clk);
    end
    rchk(1, 8'h04);
    // Busy output and request held until busy falls
    wr_reg(0, 8'h00);
    cmd_busy <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    chk({7'h0, pwr}, 8'h01);
    fork
      host.request(n);
      begin
        repeat (10) @(posedge clk);
        #1;
        chk({7'h0, rts}, 8'h01);
        @(posedge clk);
        cmd_busy <= 1'b0;
      end
    join
    win(11, 20);
    repeat (3) @(posedge clk);
    #1;
    chk({6'h0, pwr, rts}, 8'h00);
    rchk(1, 8'h04);
    // Monitor mode: glitch, debounce, standby, wake by either delay
    wr_reg(2, 8'h03);
    for (int w = 0; w < 2; w++) begin
      wr_reg(0, w ? 8'h86 : 8'h84);
      host.set_ign(1'b0);
      repeat (DEB - 3) @(posedge clk);
      host.set_ign(1'b1);
      repeat (6) @(posedge clk);
      #1;
      chk({7'h0, osc}, 8'h01);
      host.set_ign(1'b0);
      #1;
      cnt_until(0, 1'b0);
      win(DEB - 1, DEB + 4);
      repeat (2) @(posedge clk);
      #1;
      chk({6'h0, pwr, irq}, 8'h03);
      rchk(3, 8'h02);
      host.set_ign(1'b1);
      #1;
      cnt_until(1, 1'b1);
      win((w ? WL : WS) - 1, (w ? WL : WS) + 5);
      rchk(1, 8'h03);
      chk({7'h0, irq}, 8'h00);
    end
    // Sleep command, wake by a rising request edge
    wr_reg(0, 8'hc0);
    sleep_via(0, SLP, 1'b0);
    host.set_ign(1'b0);
    host.set_ign(1'b1);
    #1;
    cnt_until(1, 1'b1);
    win(WS - 1, WS + 5);
    repeat (2) @(posedge clk);
    #1;
    chk({6'h0, osc, pwr}, 8'h03);
    // Warning, then short and full receive-line pulses
    wr_reg(0, 8'h80);
    sleep_via(1, WRN, 1'b1);
    host.wake_pulse(RX_WAKE_CYC - 40);
    repeat (10) @(posedge clk);
    #1;
    chk({7'h0, osc}, 8'h00);
    host.wake_pulse(RX_WAKE_CYC + 2);
    #1;
    cnt_until(1, 1'b1);
    win(WS - 8, WS + 5);
    // Voltage reply delay and its interrupt
    rd_reg(1);
    wr_reg(2, 8'h08);
    pulse(2);
    cnt_until(2, 1'b1);
    win(ADC, ADC + 1);
    @(posedge clk);
    #1;
    chk({7'h0, irq}, 8'h01);
    rchk(1, 8'h08);
    chk({7'h0, irq}, 8'h00);
    stop_test();
  end
endmodule // tb_power_control_pin_functions
`default_nettype wire
